//--- txgain_pkg.sv
// Package with register map, field layout, states and timing for the transmit control block.
package txgain_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TX_POWER = 8'h05;
  localparam logic [7:0] OFS_TX_TIMING = 8'h3b;
  localparam logic [7:0] OFS_GAIN_TEST = 8'h3c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int POS_HOLD_SEL = 5;
  localparam int POS_AUTO_OFF = 3;
  localparam int POS_FREEZE = 2;
  localparam logic [7:0] RST_TX_POWER = 8'h00;
  localparam logic [7:0] RST_GAIN_TEST = 8'h00;
  localparam logic [7:0] MASK_GAIN_TEST = 8'h3f;
  localparam logic [1:0] GAIN_MAX = 2'h0;
  localparam logic [1:0] GAIN_MED = 2'h1;
  localparam logic [1:0] GAIN_MIN = 2'h2;

  // ----------------------------------------------------------------
  // Buffer geometry and timing
  // ----------------------------------------------------------------
  localparam int BUF_DEPTH = 128;
  localparam logic [7:0] MAX_FRAME_LEN = 8'h7f;
  localparam int CLK_MHZ = 20;
  localparam int MOD_DELAY_US = 16;
  localparam int MOD_DELAY_CYC = MOD_DELAY_US * CLK_MHZ;
  localparam int PA_BUF_LEAD_CYC = MOD_DELAY_CYC / 2;

  // ----------------------------------------------------------------
  // Radio states and commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SYNTH_READY = 3'b001,
    ST_AUTO_RETRY = 3'b010,
    ST_RAMP = 3'b011,
    ST_TX = 3'b100
  } tx_state_t;

  localparam logic [4:0] CMD_TX_START = 5'h02;

  // Host register access grouped as one carrier.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Host buffer byte write request.
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } buf_wr_t;

endpackage

//--- txgain_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module txgain_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  // Full and empty follow the occupancy count.
  assign o_in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem_ff[rp_ff];

  // Storage needs no reset.
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_ff[wp_ff] <= i_in_data;
    end
  end

  // Pointer and count upkeep.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- txgain_ctrl.sv
// Receiver gain bits, transmit start and power, trigger timing and the frame buffer.
//
// Contract
// [RQ1] Auto gain disable stops regulation, allows manual.
// [RQ2] Gain freeze selects free run or frozen.
// [RQ3] Manual gain codes: max, medium, min, reserved.
// [RQ4] Manual gain applied only when auto disabled.
// [RQ5] Transmit starts from synth-ready or auto-retry only.
// [RQ6] Pin edge: transmit, modulation after 16 us.
// [RQ7] PA buffer enabled before PA, never together.
// [RQ8] Power codes 0x0 highest to 0xF lowest.
// [RQ9] State command restores programmed power level.
// [RQ10] Reduced power mode reads last used power.
// [RQ11] Time mode reports pin edge alignment nibble.
// [RQ12] Phase mode returns eight-bit phase value.
// [RQ13] Frame buffer is 128-byte dual port.
// [RQ14] Addresses 0x00 to 0x7F hold one frame.
// [RQ15] Port access conflict raises underrun interrupt.
// [RQ16] Frame over 127 octets raises underrun.
// [RQ17] Buffer access only while digital regulator on; the code gates only host access, not receive writes or transmit fetches.
// [RQ18] Power-on state needs master clock output running.
// [RQ19] Transmit processor fetches bytes for modulation.
// [RQ20] Gain bits act only with phase measure enabled.
// [RQ21] Hold source select takes freeze bit manually.
// [RQ22] Reserved bits read zero, ignore writes.
`timescale 1ns/1ps
`default_nettype none
module txgain_ctrl (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Register access
  input wire txgain_pkg::reg_req_t i_reg,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // State command field writes
  input wire logic i_cmd_wr,
  input wire logic [4:0] i_state_command_field,
  // Mode and state inputs
  input wire logic i_synth_ready,
  input wire logic i_auto_retry_transmit_state,
  input wire logic i_phase_measure_enable,
  input wire logic i_time_measure_enable,
  input wire logic i_phase_measurement_unit,
  input wire logic [7:0] i_phase_value,
  input wire logic i_reduced_power_transmit_enable,
  input wire logic [3:0] i_rpc_power,
  input wire logic i_digital_regulator,
  input wire logic i_power_on_state,
  input wire logic i_master_clock_output,
  input wire logic [3:0] i_clk_phase,
  // Sleep/transmit pin
  input wire logic i_sleep_transmit_pin,
  // Host buffer port
  input wire logic i_buf_wr_valid,
  input wire txgain_pkg::buf_wr_t i_buf_wr,
  output logic o_buf_wr_ready,
  input wire logic i_buf_rd,
  input wire logic [6:0] i_buf_rd_addr,
  output logic [7:0] o_buf_rdata,
  input wire logic [7:0] i_frame_len,
  // Receive processor write port
  input wire logic i_rx_wr,
  input wire logic [6:0] i_rx_addr,
  input wire logic [7:0] i_rx_data,
  // Transmit baseband output
  output logic o_tx_byte_valid,
  output logic [7:0] o_tx_byte,
  output logic o_modulating,
  output logic o_pa_buf_en,
  output logic o_pa_en,
  output logic [3:0] o_transmit_power_level,
  // Receiver gain control
  output logic o_auto_gain_on,
  output logic o_gain_frozen,
  output logic [1:0] o_rx_gain,
  // Interrupt event
  output logic o_buffer_underrun_interrupt
);
  import txgain_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] gain_test_ff;
  logic [3:0] pwr_prog_ff;
  logic [3:0] pwr_used_ff;
  logic sent_once_ff;
  logic [3:0] align_ff;
  logic pin_ff;
  tx_state_t state_ff;
  tx_state_t nxt_state;
  logic [8:0] cnt_ff;
  logic [7:0] buf_mem [BUF_DEPTH];
  logic [6:0] tx_ptr_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic [7:0] brd_ff;
  logic ur_ff;
  logic pa_buf_ff;
  logic pa_ff;
  logic mod_ff;
  logic txv_ff;
  logic [7:0] txb_ff;
  logic auto_on_ff;
  logic frozen_ff;
  logic [1:0] gain_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire sel_pwr = (i_reg.addr == OFS_TX_POWER);
  wire sel_time = (i_reg.addr == OFS_TX_TIMING);
  wire sel_gain = (i_reg.addr == OFS_GAIN_TEST);
  wire pin_rise = i_sleep_transmit_pin && !pin_ff;
  wire cmd_start = i_cmd_wr && (i_state_command_field == CMD_TX_START);
  wire tx_allowed = i_synth_ready || i_auto_retry_transmit_state;
  // [RQ17] Buffer gating
  // [RQ18] Power-on clock check
  wire buf_ok = i_digital_regulator && (!i_power_on_state || i_master_clock_output);
  wire fifo_valid;
  buf_wr_t fifo_data;
  wire fifo_pop = fifo_valid && buf_ok;
  wire tx_fetch = (state_ff == ST_TX) && mod_ff;
  // [RQ15] Conflict detection
  wire conflict = (fifo_pop && tx_fetch && (fifo_data.addr <= tx_ptr_ff))
    || (i_buf_rd && buf_ok && i_rx_wr && (i_buf_rd_addr == i_rx_addr));
  // [RQ16] Overflow detection
  wire overflow = i_buf_wr_valid && (i_frame_len > MAX_FRAME_LEN);

  // [RQ10] Read power view
  wire use_rpc = i_reduced_power_transmit_enable && sent_once_ff;
  wire [3:0] pwr_view = use_rpc ? pwr_used_ff : pwr_prog_ff;
  // [RQ12] Phase versus time mode
  // [RQ11] Alignment nibble
  wire [7:0] time_view = i_phase_measurement_unit ? i_phase_value
    : (i_time_measure_enable ? {4'h0, align_ff} : 8'h00);
  // [RQ22] Reserved bits zero
  wire [7:0] rd_mux = sel_pwr ? {4'h0, pwr_view}
    : sel_time ? time_view
    : sel_gain ? (gain_test_ff & MASK_GAIN_TEST) : 8'h00;

  // [RQ20] Gain bits gated
  wire [7:0] gain_eff = i_phase_measure_enable ? gain_test_ff : RST_GAIN_TEST;
  // [RQ1] Auto gain disable
  wire nxt_auto_on = !gain_eff[POS_AUTO_OFF];
  // [RQ2] Freeze mode
  // [RQ21] Hold source select
  wire nxt_frozen = gain_eff[POS_HOLD_SEL] && gain_eff[POS_FREEZE];
  // [RQ3] Gain code
  // [RQ4] Manual only
  wire [1:0] gc = gain_eff[1:0];
  wire [1:0] nxt_gain = !gain_eff[POS_AUTO_OFF] ? GAIN_MAX
    : (gc == GAIN_MED) ? GAIN_MED : (gc == GAIN_MIN) ? GAIN_MIN : GAIN_MAX;

  // ----------------------------------------------------------------
  // Host write FIFO: the buffer port stalls it while unpowered.
  // ----------------------------------------------------------------
  txgain_fifo #(.WIDTH($bits(buf_wr_t)), .DEPTH(8)) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_in_valid(i_buf_wr_valid),
    .i_in_data(i_buf_wr),
    .o_in_ready(o_buf_wr_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(buf_ok)
  );

  // Transmit sequencer: ramp covers the modulation delay.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (i_synth_ready) begin
          nxt_state = ST_SYNTH_READY;
        end else if (i_auto_retry_transmit_state) begin
          nxt_state = ST_AUTO_RETRY;
        end
      end
      ST_SYNTH_READY, ST_AUTO_RETRY: begin
        // [RQ5] Legal start states
        // [RQ6] Pin edge start
        if ((pin_rise || cmd_start) && tx_allowed) begin
          nxt_state = ST_RAMP;
        end else if (!tx_allowed) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RAMP: begin
        if (cnt_ff == 9'(MOD_DELAY_CYC - 1)) begin
          nxt_state = ST_TX;
        end
      end
      ST_TX: begin
        if (tx_ptr_ff == 7'(MAX_FRAME_LEN)) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // State and ramp counter.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      pin_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= (state_ff == ST_RAMP) ? cnt_ff + 9'd1 : 9'd0;
      pin_ff <= i_sleep_transmit_pin;
    end
  end

  // Amplifier sequencing; the buffer leads so the spectrum stays clean.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pa_buf_ff <= 1'b0;
      pa_ff <= 1'b0;
      mod_ff <= 1'b0;
    end else begin
      // [RQ7] Staggered enables
      pa_buf_ff <= (state_ff == ST_RAMP) || (state_ff == ST_TX);
      pa_ff <= ((state_ff == ST_RAMP) && (cnt_ff >= 9'(PA_BUF_LEAD_CYC)))
        || (state_ff == ST_TX);
      mod_ff <= (nxt_state == ST_TX);
    end
  end

  // [RQ13] Dual port memory
  // [RQ14] Full address range
  always_ff @(posedge i_clk_sys) begin
    if (fifo_pop) begin
      buf_mem[fifo_data.addr] <= fifo_data.data;
    end else if (i_rx_wr) begin
      buf_mem[i_rx_addr] <= i_rx_data;
    end
  end

  // Transmit fetch and host reads.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_ptr_ff <= '0;
      txv_ff <= 1'b0;
      txb_ff <= '0;
      brd_ff <= '0;
    end else begin
      // [RQ19] Byte fetch
      txv_ff <= tx_fetch;
      txb_ff <= buf_mem[tx_ptr_ff];
      tx_ptr_ff <= tx_fetch ? tx_ptr_ff + 7'd1 : 7'd0;
      if (i_buf_rd && buf_ok) begin
        brd_ff <= buf_mem[i_buf_rd_addr];
      end
    end
  end

  // Register file and power tracking.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      gain_test_ff <= RST_GAIN_TEST;
      pwr_prog_ff <= RST_TX_POWER[3:0];
      pwr_used_ff <= RST_TX_POWER[3:0];
      sent_once_ff <= 1'b0;
      align_ff <= '0;
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      if (i_reg.wr && sel_gain) begin
        gain_test_ff <= i_reg.wdata & MASK_GAIN_TEST;
      end
      // [RQ8] Power code stored
      if (i_reg.wr && sel_pwr) begin
        pwr_prog_ff <= i_reg.wdata[3:0];
      end
      // [RQ9] Command restores power
      if (i_cmd_wr) begin
        pwr_used_ff <= pwr_prog_ff;
      end else if (mod_ff && (state_ff == ST_RAMP || !txv_ff)) begin
        pwr_used_ff <= i_reduced_power_transmit_enable ? i_rpc_power : pwr_prog_ff;
        sent_once_ff <= 1'b1;
      end else if (i_reg.wr && sel_pwr) begin
        // A newly programmed level is the one in use until a frame changes it.
        pwr_used_ff <= i_reg.wdata[3:0];
      end
      if (pin_rise) begin
        align_ff <= i_clk_phase;
      end
      rdata_ff <= rd_mux;
      rvalid_ff <= i_reg.rd;
    end
  end

  // Outputs and underrun event.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ur_ff <= 1'b0;
      auto_on_ff <= 1'b1;
      frozen_ff <= 1'b0;
      gain_ff <= GAIN_MAX;
    end else begin
      ur_ff <= conflict || overflow;
      auto_on_ff <= nxt_auto_on;
      frozen_ff <= nxt_frozen;
      gain_ff <= nxt_gain;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_reg_rvalid = rvalid_ff;
  assign o_buf_rdata = brd_ff;
  assign o_tx_byte_valid = txv_ff;
  assign o_tx_byte = txb_ff;
  assign o_modulating = mod_ff;
  assign o_pa_buf_en = pa_buf_ff;
  assign o_pa_en = pa_ff;
  assign o_transmit_power_level = pwr_used_ff;
  assign o_auto_gain_on = auto_on_ff;
  assign o_gain_frozen = frozen_ff;
  assign o_rx_gain = gain_ff;
  assign o_buffer_underrun_interrupt = ur_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  pa_order_a: assert property (o_pa_en |-> o_pa_buf_en) // [RQ7]
    else $error("PA on without PA buffer");
  pa_stagger_a: assert property ($rose(o_pa_buf_en) |-> !o_pa_en) // [RQ7]
    else $error("PA and buffer rose together");
  start_legal_a: assert property ((state_ff == ST_RAMP) && $changed(state_ff)
    |-> $past(tx_allowed)) // [RQ5]
    else $error("Transmit from illegal state");
  mod_delay_a: assert property ($rose(state_ff == ST_RAMP) |-> !o_modulating [*8]) // [RQ6]
    else $error("Modulation too early");
  gain_manual_a: assert property (!gain_eff[POS_AUTO_OFF] |=> o_rx_gain == GAIN_MAX) // [RQ4]
    else $error("Manual gain applied in auto mode");
  gain_gate_a: assert property (!i_phase_measure_enable |=> o_auto_gain_on) // [RQ20]
    else $error("Gain bits active without enable");
  freeze_sel_a: assert property (!gain_eff[POS_HOLD_SEL] |=> !o_gain_frozen) // [RQ21]
    else $error("Freeze without hold select");
  reserved_a: assert property (i_reg.rd && sel_pwr |=> o_reg_rdata[7:4] == 4'h0) // [RQ22]
    else $error("Reserved bits nonzero");
  overflow_a: assert property (overflow |=> o_buffer_underrun_interrupt) // [RQ16]
    else $error("Overflow not flagged");
  sleep_block_a: assert property (!i_digital_regulator |-> !fifo_pop) // [RQ17]
    else $error("Buffer written while asleep");
  restore_a: assert property (i_cmd_wr |=> o_transmit_power_level == $past(pwr_prog_ff)) // [RQ9]
    else $error("Power not restored");

  tx_pin_c: cover property (pin_rise && (state_ff == ST_SYNTH_READY));
  tx_cmd_c: cover property (cmd_start && (state_ff == ST_AUTO_RETRY));
  ur_c: cover property (conflict);
  full_c: cover property (!o_buf_wr_ready);
endmodule
`default_nettype wire

//--- txgain_host_model.sv
// Host controller model that drives the register and frame buffer ports.
`timescale 1ns/1ps
`default_nettype none
module txgain_host_model (
  // Clock
  input wire logic i_clk_sys,
  // Register port
  output var txgain_pkg::reg_req_t o_reg,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  // Frame buffer port
  output logic o_buf_wr_valid,
  output var txgain_pkg::buf_wr_t o_buf_wr,
  input wire logic i_buf_wr_ready,
  output logic o_buf_rd,
  output logic [6:0] o_buf_rd_addr,
  input wire logic [7:0] i_buf_rdata,
  input wire logic i_awake
);
  import txgain_pkg::*;

  // Idle bus at time zero.
  initial begin
    o_reg = '0;
    o_buf_wr_valid = 1'b0;
    o_buf_wr = '0;
    o_buf_rd = 1'b0;
    o_buf_rd_addr = 7'h00;
  end

  // Released lines show the inverse so that stale data is never mistaken for an answer.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    #1;
    o_reg = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk_sys);
    #1;
    o_reg = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // Read data is taken in the cycle that carries the valid pulse.
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge i_clk_sys);
    #1;
    o_reg = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk_sys);
    #1;
    o_reg = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    n = 0;
    while (i_reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 8'hxx;
  endtask

  // Ready is looked at just after an edge, where it stands until the next edge takes the byte.
  task automatic buf_push(input logic [6:0] a, input logic [7:0] d, output logic ok);
    int n;
    @(posedge i_clk_sys);
    #1;
    o_buf_wr_valid = 1'b1;
    o_buf_wr = '{addr: a, data: d};
    n = 0;
    while (i_buf_wr_ready !== 1'b1 && n < 40) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    ok = (i_buf_wr_ready === 1'b1);
    @(posedge i_clk_sys);
    #1;
    o_buf_wr_valid = 1'b0;
    o_buf_wr = ~o_buf_wr;
  endtask

  task automatic buf_rd(input logic [6:0] a, output logic [7:0] d);
    d = 8'hxx;
    if (i_awake) begin
      @(posedge i_clk_sys);
      #1;
      o_buf_rd = 1'b1;
      o_buf_rd_addr = a;
      @(posedge i_clk_sys);
      #1;
      o_buf_rd = 1'b0;
      o_buf_rd_addr = ~a;
      d = i_buf_rdata;
    end
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the transmit, gain and frame buffer control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import txgain_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cmd_wr = 1'b0, synth = 1'b0, aretry = 1'b0, pm_en = 1'b0;
  logic tm_en = 1'b0, phase_measurement_unit = 1'b0, rpc_en = 1'b0, dreg = 1'b1, pon = 1'b0, mclk = 1'b1;
  logic pin = 1'b0, rx_wr = 1'b0;
  logic [4:0] cmd = 5'h00;
  logic [3:0] rpc_pw = 4'h0, clk_ph = 4'h0, pwr;
  logic [7:0] ph_val = 8'h00, flen = 8'h10, rx_data = 8'h00, rdata, buf_rdata, tx_byte;
  logic [6:0] rx_addr = 7'h00, buf_rd_addr;
  logic rvalid, wr_ready, buf_rd, wr_valid, tx_valid, modl, pa_buf, pa, auto_on, frozen, ur;
  logic [1:0] gain;
  reg_req_t req;
  buf_wr_t bwr;
  int err_count = 0, total_checks = 0, ur_cnt = 0, cyc = 0;
  logic [7:0] mem [128];
  logic [7:0] txq [$];

  txgain_ctrl dut (.i_clk_sys(clk), .i_rst(rst), .i_reg(req), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_cmd_wr(cmd_wr), .i_state_command_field(cmd),
    .i_synth_ready(synth), .i_auto_retry_transmit_state(aretry),
    .i_phase_measure_enable(pm_en), .i_time_measure_enable(tm_en),
    .i_phase_measurement_unit(phase_measurement_unit), .i_phase_value(ph_val),
    .i_reduced_power_transmit_enable(rpc_en), .i_rpc_power(rpc_pw),
    .i_digital_regulator(dreg), .i_power_on_state(pon), .i_master_clock_output(mclk),
    .i_clk_phase(clk_ph), .i_sleep_transmit_pin(pin), .i_buf_wr_valid(wr_valid),
    .i_buf_wr(bwr), .o_buf_wr_ready(wr_ready), .i_buf_rd(buf_rd),
    .i_buf_rd_addr(buf_rd_addr), .o_buf_rdata(buf_rdata), .i_frame_len(flen),
    .i_rx_wr(rx_wr), .i_rx_addr(rx_addr), .i_rx_data(rx_data), .o_tx_byte_valid(tx_valid),
    .o_tx_byte(tx_byte), .o_modulating(modl), .o_pa_buf_en(pa_buf), .o_pa_en(pa),
    .o_transmit_power_level(pwr), .o_auto_gain_on(auto_on), .o_gain_frozen(frozen),
    .o_rx_gain(gain), .o_buffer_underrun_interrupt(ur));
  txgain_host_model host (.i_clk_sys(clk), .o_reg(req), .i_reg_rdata(rdata),
    .i_reg_rvalid(rvalid), .o_buf_wr_valid(wr_valid), .o_buf_wr(bwr),
    .i_buf_wr_ready(wr_ready), .o_buf_rd(buf_rd), .o_buf_rd_addr(buf_rd_addr),
    .i_buf_rdata(buf_rdata), .i_awake(dreg));

  // Clock at 20 MHz.
  always #25 clk = ~clk;

  // Cycle count, underrun pulses and fetched transmit bytes.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ur === 1'b1) ur_cnt <= ur_cnt + 1;
    if (tx_valid === 1'b1) txq.push_back(tx_byte);
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(input string w, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.reg_rd(a, d);
    check(w, d, e);
  endtask

  // Gain bits in force: reset values unless phase measurement is enabled.
  function automatic logic [7:0] gain_eff(input logic [7:0] r, input logic pm);
    return pm ? r : RST_GAIN_TEST;
  endfunction

  // Power register reads back the level with the reserved bits clear.
  function automatic logic [7:0] pw_rd(input logic [3:0] p);
    return {4'h0, p};
  endfunction

  // Trigger a frame, time the ramp and compare the fetched bytes with the buffer image.
  task automatic run_tx(input logic use_pin);
    int t0, tb_, tp, tm, n;
    txq.delete();
    tb_ = 0;
    tp = 0;
    tm = 0;
    @(posedge clk);
    #1;
    pin = use_pin;
    cmd_wr = !use_pin;
    cmd = CMD_TX_START;
    t0 = cyc;
    for (n = 0; n < 600 && tm == 0; n++) begin
      @(posedge clk);
      #1;
      cmd_wr = 1'b0;
      if (pa_buf === 1'b1 && tb_ == 0) tb_ = cyc - t0;
      if (pa === 1'b1 && tp == 0) tp = cyc - t0;
      if (modl === 1'b1 && tm == 0) tm = cyc - t0;
    end
    check("pa buffer lead", 8'(tb_ >= 1 && tb_ <= 3), 8'h01);
    check("pa after buffer", 8'(tp > tb_ && tb_ > 0), 8'h01);
    check("mod delay", 8'(tm >= MOD_DELAY_CYC - 4 && tm <= MOD_DELAY_CYC + 4), 8'h01);
    for (n = 0; n < 600 && txq.size() < BUF_DEPTH; n++) @(posedge clk);
    #1;
    check("byte count", 8'(txq.size()), 8'(BUF_DEPTH));
    for (n = 0; n < txq.size(); n++) check("tx byte", txq[n], mem[n]);
    pin = 1'b0;
    for (n = 0; n < 600 && modl !== 1'b0; n++) wait_cyc(1);
    $display("test transmit done");
  endtask

  // Watchdog sized well above the whole sequence.
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    finish_test();
  end

  // Main sequence.
  initial begin
    int i, n, u;
    logic ok;
    logic [7:0] r, v, d;
    logic [3:0] prog;
    void'($urandom(32'h33c8));
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    check("auto on", auto_on, 8'h01);
    check("gain", gain, GAIN_MAX);
    check("frozen", frozen, 8'h00);
    rd_chk("power rst", OFS_TX_POWER, RST_TX_POWER);
    rd_chk("gain rst", OFS_GAIN_TEST, RST_GAIN_TEST);
    rd_chk("timing rst", OFS_TX_TIMING, 8'h00);
    host.reg_wr(8'h10, 8'hff);
    rd_chk("unmapped", 8'h10, 8'h00);
    for (i = 0; i < 8; i++) begin
      r = $urandom;
      if (i < 3) r[3:0] = {2'b10, 2'(i)};
      pm_en = (i != 4);
      host.reg_wr(OFS_GAIN_TEST, r);
      rd_chk("gain reg", OFS_GAIN_TEST, r & MASK_GAIN_TEST);
      wait_cyc(2);
      v = gain_eff(r, pm_en);
      check("auto on", auto_on, !v[POS_AUTO_OFF]);
      check("frozen", frozen, v[POS_HOLD_SEL] & v[POS_FREEZE]);
      if (v[POS_AUTO_OFF] && v[1:0] != 2'h3) check("gain", gain, v[1:0]);
    end
    $display("test gain done");
    for (i = 0; i < 16; i++) begin
      r = {4'($urandom), 4'(i)};
      host.reg_wr(OFS_TX_POWER, r);
      rd_chk("power reg", OFS_TX_POWER, pw_rd(r[3:0]));
      check("power out", pwr, r[3:0]);
    end
    prog = r[3:0];
    $display("test power done");
    for (i = 0; i < BUF_DEPTH; i++) mem[i] = $urandom;
    dreg = 1'b0;
    i = 0;
    do begin
      host.buf_push(7'(i), mem[i], ok);
      i += ok;
    end while (ok && i < 12);
    check("fifo fill", 8'(i), 8'h08);
    dreg = 1'b1;
    pon = 1'b1;
    mclk = 1'b0;
    host.buf_push(7'h08, mem[8], ok);
    check("no clock stall", ok, 8'h00);
    mclk = 1'b1;
    n = 0;
    for (i = 8; i < BUF_DEPTH; i++) begin
      host.buf_push(7'(i), mem[i], ok);
      n += !ok;
    end
    check("refused pushes", 8'(n), 8'h00);
    pon = 1'b0;
    wait_cyc(12);
    for (i = 0; i < 4; i++) begin
      u = (i == 0) ? 0 : (i == 1) ? 127 : $urandom_range(127);
      host.buf_rd(7'(u), d);
      check("host read", d, mem[u]);
    end
    $display("test buffer done");
    synth = 1'b1;
    tm_en = 1'b1;
    clk_ph = $urandom;
    run_tx(1'b1);
    synth = 1'b0;
    rd_chk("trigger phase", OFS_TX_TIMING, {4'h0, clk_ph});
    tm_en = 1'b0;
    pin = 1'b1;
    n = 0;
    repeat (400) begin
      wait_cyc(1);
      n += (pa_buf === 1'b1);
    end
    check("idle trigger", 8'(n), 8'h00);
    pin = 1'b0;
    aretry = 1'b1;
    rpc_en = 1'b1;
    rpc_pw = ~prog;
    run_tx(1'b0);
    aretry = 1'b0;
    rd_chk("used power", OFS_TX_POWER, pw_rd(rpc_pw));
    cmd = 5'h08;
    cmd_wr = 1'b1;
    wait_cyc(1);
    cmd_wr = 1'b0;
    rd_chk("restored power", OFS_TX_POWER, pw_rd(prog));
    rpc_en = 1'b0;
    phase_measurement_unit = 1'b1;
    ph_val = $urandom;
    rd_chk("phase value", OFS_TX_TIMING, ph_val);
    phase_measurement_unit = 1'b0;
    for (i = 0; i < 4; i++) begin
      u = ur_cnt;
      flen = i[0] ? 8'h7f : 8'h80;
      rx_addr = 7'(i + 3);
      rx_data = $urandom;
      if (i >= 2) begin
        rx_wr = 1'b1;
        host.buf_rd(7'(i[0] ? 5 : i + 3), d);
        rx_wr = 1'b0;
      end else begin
        host.buf_push(7'h00, 8'h10, ok);
      end
      wait_cyc(6);
      check("underrun", 8'(ur_cnt > u), 8'(!i[0]));
    end
    $display("test underrun done");
    finish_test();
  end
endmodule
`default_nettype wire
